//--- hw/clst_map.svh
// Register offsets, field positions and limits of the latency stopwatch.
// Assumes a 12-bit APB byte address with one 32-bit word per register.
`ifndef CLST_MAP_SVH
`define CLST_MAP_SVH

`define CLST_ADDR_W        12
`define CLST_ADDR_CTRL     12'h000
`define CLST_ADDR_RESULT   12'h004
`define CLST_ADDR_STATUS   12'h008

`define CLST_CTRL_CHAN     0
`define CLST_CTRL_START    1
`define CLST_CTRL_STOP     2
`define CLST_CTRL_CLKSRC   3
`define CLST_CTRL_DIV_LO   4
`define CLST_CTRL_DIV_HI   5
`define CLST_CTRL_MANUAL   6
`define CLST_CTRL_REARM    7

`define CLST_STAT_RUN      0
`define CLST_STAT_HELD     1
`define CLST_STAT_STRAP    2

`define CLST_RESULT_W      20
`define CLST_RESULT_MAX    20'hfffff
`define CLST_COMMA_A       8'h3c
`define CLST_COMMA_B       8'hbc
`define CLST_COMMA_C       8'hfc
`define CLST_TAPS          4

`endif

//--- hw/clst_pkg.sv
// Types shared by the latency stopwatch modules.
// Assumes clst_map.svh is on the include path.
`default_nettype none
`include "clst_map.svh"

package clst_pkg;

  typedef enum logic [2:0] {
    CLST_ARMED = 3'b001,
    CLST_RUN   = 3'b010,
    CLST_HELD  = 3'b100
  } clst_state_t;

  typedef logic [`CLST_RESULT_W-1:0] clst_count_t;

endpackage : clst_pkg

`default_nettype wire

//--- hw/clst_stopwatch.sv
// Comma latency stopwatch: APB registers, measurement clock enable, counter and hold logic.
// Assumes hs_tick_in and byte_tick_in are one-cycle enables on clk_sys_in, one per rising
// edge of each channel's measurement clock; the strap pin is asynchronous.
//
// Function
// - Commas are K bytes 3c, bc, fc
// - Two start and two stop taps selectable
// - One channel measured, both taps same channel
// - First start comma starts; later ones ignored
// - First stop comma after start halts count
// - Elapsed count readable as 20-bit result
// - Overrange reports saturated fffff, never wraps
// - One result held until host reads it
// - No start comma seen reads as zero
// - Manual mode follows strap pin level
// - Fast tick is bit rate over 8/4/2/1
// - Register divider 1, 2, 4 or 8
// - Measurement clock from tested channel only
// - Optional recovered byte clock, bit rate/20
// - Result within one measurement period
//
// Local design decisions: register access over APB and the register addresses.
`default_nettype none
`include "clst_map.svh"

module clst_stopwatch
  import clst_pkg::*;
(
  input  wire logic                            clk_sys_in,
  input  wire logic                            rst_in,
  // APB slave
  input  wire logic                            psel_in,
  input  wire logic                            penable_in,
  input  wire logic                            pwrite_in,
  input  wire logic [`CLST_ADDR_W-1:0]         paddr_in,
  input  wire logic [31:0]                     pwdata_in,
  output logic      [31:0]                     prdata_out,
  output logic                                 pready_out,
  output logic                                 pslverr_out,
  // Data path taps, per channel: 0/1 start, 2/3 stop
  input  wire logic [1:0][`CLST_TAPS-1:0][7:0] tap_data_in,
  input  wire logic [1:0][`CLST_TAPS-1:0]      tap_ctrl_in,
  // Measurement clock enables per channel
  input  wire logic [1:0]                      hs_tick_in,
  input  wire logic [1:0]                      byte_tick_in,
  // Manual start/stop strap
  input  wire logic                            manual_trigger_strap_pin_in,
  // Status
  output logic                                 meas_running_out,
  output logic                                 result_held_out
);

  typedef struct packed {
    clst_state_t st;
    clst_count_t cnt;
    logic        chan;
    logic        start_sel;
    logic        stop_sel;
    logic        clk_src;
    logic [1:0]  div;
    logic        manual;
    logic [2:0]  divcnt;
    logic        strap_m;
    logic        strap_s;
    logic [31:0] prdata;
  } clst_core_t;

  clst_core_t s_q;
  clst_core_t s_d;

  clst_tap_if tap ();

  clst_tap_sel u_tap_sel (
    .clk_sys_in  (clk_sys_in),
    .rst_in      (rst_in),
    .tap_data_in (tap_data_in),
    .tap_ctrl_in (tap_ctrl_in),
    .tap         (tap.sel)
  );

  assign tap.chan_sel  = s_q.chan;
  assign tap.start_sel = s_q.start_sel;
  assign tap.stop_sel  = s_q.stop_sel;

  // Address decode used in the access phase for writes, reads and slave error
  function automatic logic clst_mapped(input logic [`CLST_ADDR_W-1:0] a);
    clst_mapped = (a == `CLST_ADDR_CTRL) || (a == `CLST_ADDR_RESULT) || (a == `CLST_ADDR_STATUS);
  endfunction : clst_mapped

  // Mask of divider stages for 1, 2, 4 or 8
  function automatic logic [2:0] clst_div_mask(input logic [1:0] d);
    unique case (d)
      2'h0: clst_div_mask = 3'h0;
      2'h1: clst_div_mask = 3'h1;
      2'h2: clst_div_mask = 3'h3;
      2'h3: clst_div_mask = 3'h7;
    endcase
  endfunction : clst_div_mask

  logic raw_tick;
  logic meas_tick;
  logic apb_access;
  logic apb_wr;
  logic apb_rd;
  logic setup;

  assign setup      = psel_in && !penable_in;
  assign apb_access = psel_in && penable_in;
  assign apb_wr     = apb_access && pwrite_in && clst_mapped(paddr_in);
  assign apb_rd     = apb_access && !pwrite_in && clst_mapped(paddr_in);

  // Fast tick arrives already at the bit rate over 8, 4, 2 or 1 for the line rate
  assign raw_tick  = s_q.clk_src ? byte_tick_in[s_q.chan]
                                 : hs_tick_in[s_q.chan];
  assign meas_tick = raw_tick && ((s_q.divcnt & clst_div_mask(s_q.div)) == clst_div_mask(s_q.div));

  always_comb begin
    logic start_ev;
    logic stop_ev;
    logic rearm;
    start_ev = 1'b0;
    stop_ev  = 1'b0;
    rearm    = 1'b0;
    s_d      = s_q;

    // Strap synchroniser
    s_d.strap_m = manual_trigger_strap_pin_in;
    s_d.strap_s = s_q.strap_m;

    if (raw_tick) begin
      s_d.divcnt = s_q.divcnt + 3'h1;
    end

    // Start and stop causes
    if (s_q.manual) begin
      start_ev = s_q.strap_s;
      stop_ev  = !s_q.strap_s;
    end else begin
      start_ev = tap.start_hit;
      stop_ev  = tap.stop_hit;
    end

    // Register writes
    if (apb_wr && paddr_in == `CLST_ADDR_CTRL) begin
      s_d.chan      = pwdata_in[`CLST_CTRL_CHAN];
      s_d.start_sel = pwdata_in[`CLST_CTRL_START];
      s_d.stop_sel  = pwdata_in[`CLST_CTRL_STOP];
      s_d.clk_src   = pwdata_in[`CLST_CTRL_CLKSRC];
      s_d.div       = pwdata_in[`CLST_CTRL_DIV_HI:`CLST_CTRL_DIV_LO];
      s_d.manual    = pwdata_in[`CLST_CTRL_MANUAL];
      rearm         = pwdata_in[`CLST_CTRL_REARM];
    end

    unique case (s_q.st)
      CLST_ARMED: begin
        if (start_ev) begin
          s_d.st     = CLST_RUN;
          s_d.cnt    = '0;
          s_d.divcnt = 3'h0;
        end
      end
      CLST_RUN: begin
        // Later start commas are not looked at here
        if (stop_ev) begin
          s_d.st = CLST_HELD;
        end else if (meas_tick && s_q.cnt != `CLST_RESULT_MAX) begin
          s_d.cnt = s_q.cnt + 20'h00001;
        end
        // Saturated count stays at all ones
        if (meas_tick && s_q.cnt == `CLST_RESULT_MAX) begin
          s_d.cnt = `CLST_RESULT_MAX;
        end
      end
      CLST_HELD: begin
        // Only a result read or a CTRL write with REARM set clears the result
        if (apb_rd && paddr_in == `CLST_ADDR_RESULT) begin
          s_d.st  = CLST_ARMED;
          s_d.cnt = '0;
        end
      end
      default: begin
        s_d.st  = CLST_ARMED;
        s_d.cnt = '0;
      end
    endcase

    if (rearm) begin
      s_d.st  = CLST_ARMED;
      s_d.cnt = '0;
    end

    // Read data is fetched in the setup phase
    if (setup && !pwrite_in) begin
      s_d.prdata = 32'h0000_0000;
      if (paddr_in == `CLST_ADDR_CTRL) begin
        s_d.prdata[`CLST_CTRL_CHAN]                      = s_q.chan;
        s_d.prdata[`CLST_CTRL_START]                     = s_q.start_sel;
        s_d.prdata[`CLST_CTRL_STOP]                      = s_q.stop_sel;
        s_d.prdata[`CLST_CTRL_CLKSRC]                    = s_q.clk_src;
        s_d.prdata[`CLST_CTRL_DIV_HI:`CLST_CTRL_DIV_LO]  = s_q.div;
        s_d.prdata[`CLST_CTRL_MANUAL]                    = s_q.manual;
      end else if (paddr_in == `CLST_ADDR_RESULT) begin
        // Armed state holds zero, so no start reads as zero
        s_d.prdata[`CLST_RESULT_W-1:0] = s_q.cnt;
      end else if (paddr_in == `CLST_ADDR_STATUS) begin
        s_d.prdata[`CLST_STAT_RUN]   = (s_q.st == CLST_RUN);
        s_d.prdata[`CLST_STAT_HELD]  = (s_q.st == CLST_HELD);
        s_d.prdata[`CLST_STAT_STRAP] = s_q.strap_s;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s_q.st        <= CLST_ARMED;
      s_q.cnt       <= '0;
      s_q.chan      <= 1'b0;
      s_q.start_sel <= 1'b0;
      s_q.stop_sel  <= 1'b0;
      s_q.clk_src   <= 1'b0;
      s_q.div       <= 2'h0;
      s_q.manual    <= 1'b0;
      s_q.divcnt    <= 3'h0;
      s_q.strap_m   <= 1'b0;
      s_q.strap_s   <= 1'b0;
      s_q.prdata    <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata_out       = s_q.prdata;
  assign pready_out       = 1'b1;
  assign pslverr_out      = apb_access && !clst_mapped(paddr_in);
  assign meas_running_out = (s_q.st == CLST_RUN);
  assign result_held_out  = (s_q.st == CLST_HELD);

endmodule : clst_stopwatch

`default_nettype wire

//--- hw/clst_tap_if.sv
// Tap selection and comma hit signals between stopwatch core and tap selector.
// Assumes both ends run on clk_sys_in.
`default_nettype none

interface clst_tap_if;
  logic chan_sel;
  logic start_sel;
  logic stop_sel;
  logic start_hit;
  logic stop_hit;

  modport sel (input chan_sel, input start_sel, input stop_sel, output start_hit, output stop_hit);
  modport ctl (output chan_sel, output start_sel, output stop_sel, input start_hit, input stop_hit);
endinterface : clst_tap_if

`default_nettype wire

//--- hw/clst_tap_sel.sv
// Selects the start and stop taps of the channel under test and flags commas on them.
// Assumes tap bytes are valid every clk_sys_in cycle, on the same clock.
`default_nettype none
`include "clst_map.svh"

module clst_tap_sel
  import clst_pkg::*;
(
  input  wire logic                          clk_sys_in,
  input  wire logic                          rst_in,
  input  wire logic [1:0][`CLST_TAPS-1:0][7:0] tap_data_in,
  input  wire logic [1:0][`CLST_TAPS-1:0]    tap_ctrl_in,
  clst_tap_if.sel                            tap
);

  typedef struct packed {
    logic start_hit;
    logic stop_hit;
  } clst_hit_t;

  clst_hit_t s_q;
  clst_hit_t s_d;

  function automatic logic clst_is_comma(input logic k, input logic [7:0] d);
    clst_is_comma = k && (d == `CLST_COMMA_A || d == `CLST_COMMA_B || d == `CLST_COMMA_C);
  endfunction : clst_is_comma

  always_comb begin
    logic [1:0] start_idx;
    logic [1:0] stop_idx;
    start_idx   = {1'b0, tap.start_sel};
    stop_idx    = {1'b1, tap.stop_sel};
    s_d         = s_q;
    // Both taps come from the one channel under test
    s_d.start_hit = clst_is_comma(tap_ctrl_in[tap.chan_sel][start_idx],
                                  tap_data_in[tap.chan_sel][start_idx]);
    s_d.stop_hit  = clst_is_comma(tap_ctrl_in[tap.chan_sel][stop_idx],
                                  tap_data_in[tap.chan_sel][stop_idx]);
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tap.start_hit = s_q.start_hit;
  assign tap.stop_hit  = s_q.stop_hit;

endmodule : clst_tap_sel

`default_nettype wire

//--- tb/clst_stopwatch_sva.sv
// Port checker for clst_stopwatch, bound to every instance.
// Assumes the CTRL bit layout and tap order of clst_map.svh.
`default_nettype none
`include "clst_map.svh"
module clst_stopwatch_sva (
  input wire logic                clk_sys_in,
  input wire logic                rst_in,
  input wire logic                psel_in,
  input wire logic                penable_in,
  input wire logic                pwrite_in,
  input wire logic [11:0]         paddr_in,
  input wire logic [31:0]         pwdata_in,
  input wire logic [31:0]         prdata_out,
  input wire logic [1:0][3:0][7:0] tap_data_in,
  input wire logic [1:0][3:0]     tap_ctrl_in,
  input wire logic                manual_trigger_strap_pin_in,
  input wire logic                meas_running_out,
  input wire logic                result_held_out
);
  timeunit 1ns / 1ns;
  logic [7:0] ctrl_q;
  logic       st_c, sp_c, rd_res, strap;
  function automatic logic comma(input logic k, input logic [7:0] d);
    return k && (d == `CLST_COMMA_A || d == `CLST_COMMA_B || d == `CLST_COMMA_C);
  endfunction : comma
  // Shadow of CTRL as last written
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= 8'h00;
    end else if (psel_in && penable_in && pwrite_in && paddr_in == `CLST_ADDR_CTRL) begin
      ctrl_q <= pwdata_in[7:0];
    end
  end
  assign st_c = !ctrl_q[6] && comma(tap_ctrl_in[ctrl_q[0]][ctrl_q[1]], tap_data_in[ctrl_q[0]][ctrl_q[1]]);
  assign sp_c = !ctrl_q[6] && comma(tap_ctrl_in[ctrl_q[0]][{1'b1, ctrl_q[2]}], tap_data_in[ctrl_q[0]][{1'b1, ctrl_q[2]}]);
  assign rd_res = psel_in && penable_in && !pwrite_in && paddr_in == `CLST_ADDR_RESULT;
  assign strap = manual_trigger_strap_pin_in;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  a_start_count: assert property (!meas_running_out && !result_held_out && st_c && !psel_in |-> ##2 meas_running_out)
    else $error("start comma missed");
  a_arm_quiet: assert property (!meas_running_out && !result_held_out && !ctrl_q[6] && !st_c
    && !$past(st_c) && !psel_in |=> !meas_running_out) else $error("started without comma");
  a_stop_halt: assert property (meas_running_out && sp_c && !psel_in |-> ##2 result_held_out)
    else $error("stop comma missed");
  a_held_kept: assert property (result_held_out && !psel_in |=> result_held_out)
    else $error("result dropped");
  a_status_match: assert property (psel_in && !penable_in && !pwrite_in && paddr_in == `CLST_ADDR_STATUS
    |=> prdata_out[1:0] == $past({result_held_out, meas_running_out})) else $error("status bits wrong");
  a_read_rearm: assert property (result_held_out && rd_res |=> !result_held_out && !meas_running_out)
    else $error("read did not rearm");
  a_zero_armed: assert property (psel_in && !penable_in && !pwrite_in && paddr_in == `CLST_ADDR_RESULT
    && !meas_running_out && !result_held_out |=> prdata_out == 32'h0) else $error("armed read not zero");
  a_manual_go: assert property (ctrl_q[6] && !result_held_out && !psel_in && $rose(strap)
    |-> ##[1:5] meas_running_out) else $error("strap did not start");
  a_manual_halt: assert property (ctrl_q[6] && meas_running_out && $fell(strap) |-> ##[1:5] result_held_out)
    else $error("strap did not stop");
endmodule : clst_stopwatch_sva
bind clst_stopwatch clst_stopwatch_sva u_sva (.clk_sys_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .prdata_out, .tap_data_in, .tap_ctrl_in, .manual_trigger_strap_pin_in, .meas_running_out,
  .result_held_out);
`default_nettype wire

//--- tb/clst_tap_src.sv
// Channel data path stand-in: tap bytes, K flags and measurement ticks.
// Assumes the bench asks for one injected symbol per cycle on clk_sys_in.
`default_nettype none
module clst_tap_src (
  input  wire logic                clk_sys_in,
  input  wire logic                inj_in,
  input  wire logic                inj_ch_in,
  input  wire logic [1:0]          inj_tap_in,
  input  wire logic [8:0]          inj_sym_in,
  output logic [1:0][3:0][7:0]     tap_data_out,
  output logic [1:0][3:0]          tap_ctrl_out,
  output logic [1:0]               hs_tick_out,
  output logic [1:0]               byte_tick_out
);
  timeunit 1ns / 1ns;
  logic [7:0] cnt_q = 8'h00;
  always @(posedge clk_sys_in) cnt_q <= cnt_q + 8'h01;
  // Filler changes every cycle and never forms a comma
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      for (int t = 0; t < 4; t++) begin
        tap_data_out[c][t] = {cnt_q[2:0] ^ 3'(t), 5'h07};
        tap_ctrl_out[c][t] = cnt_q[3];
      end
    end
    if (inj_in) begin
      {tap_ctrl_out[inj_ch_in][inj_tap_in], tap_data_out[inj_ch_in][inj_tap_in]} = inj_sym_in;
    end
  end
  // Unequal rates per channel and source
  assign hs_tick_out = {cnt_q[0], 1'b1};
  assign byte_tick_out = {1'b1, cnt_q[1:0] == 2'b00};
endmodule : clst_tap_src
`default_nettype wire

//--- tb/tb_clst_stopwatch.sv
// Self-checking bench for clst_stopwatch: APB host, comma injection, queued read checks.
// Assumes clst_tap_src drives taps and ticks; the slave may stretch any access.
`default_nettype none
`include "clst_map.svh"
module tb_clst_stopwatch
  import clst_pkg::*;
;
  timeunit 1ns / 1ns;
  logic              clk_sys_in = 1'b0, rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic              strap = 1'b0, inj = 1'b0, inj_ch = 1'b0, pready, pslverr, running, held;
  logic [1:0]        inj_tap = 2'h0, hs, bt;
  logic [8:0]        inj_sym = 9'h000;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0, prdata;
  logic [1:0][3:0][7:0] tdata;
  logic [1:0][3:0]   tctrl;
  logic [7:0]        lfsr_q = 8'h56;
  logic [7:0]        commas [3] = '{8'h3c, 8'hbc, 8'hfc};
  logic [34:0]       exp_q [$];
  int                errors = 0, check_count = 0, cyc = 0, t_mark, s;
  clst_stopwatch uut (.clk_sys_in, .rst_in, .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .tap_data_in(tdata), .tap_ctrl_in(tctrl), .hs_tick_in(hs), .byte_tick_in(bt),
    .manual_trigger_strap_pin_in(strap), .meas_running_out(running), .result_held_out(held));
  clst_tap_src u_src (.clk_sys_in, .inj_in(inj), .inj_ch_in(inj_ch), .inj_tap_in(inj_tap), .inj_sym_in(inj_sym),
    .tap_data_out(tdata), .tap_ctrl_out(tctrl), .hs_tick_out(hs), .byte_tick_out(bt));
  initial begin
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) cyc <= cyc + 1;
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic hang;
    errors++;
    $display("wait limit reached");
    complete_run();
  endtask : hang
  // Each access checked against the oldest note; read data within its tolerance
  always @(posedge clk_sys_in) begin
    logic [34:0] e;
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check("slave error", {31'h0, pslverr}, {31'h0, e[34]});
      if (!pwrite) begin
        if (prdata >= e[31:0] - e[33:32] && prdata <= e[31:0] + e[33:32]) e[31:0] = prdata;
        check("read data", prdata, e[31:0]);
      end
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [34:0] e);
    int n;
    @(posedge clk_sys_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back(e);
    @(posedge clk_sys_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) hang();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic inject(input logic c, input logic [1:0] t, input logic [8:0] sym);
    @(posedge clk_sys_in);
    t_mark = cyc;
    inj <= 1'b1;
    inj_ch <= c;
    inj_tap <= t;
    inj_sym <= sym;
    @(posedge clk_sys_in);
    inj <= 1'b0;
  endtask : inject
  task automatic wait_held;
    int n;
    for (n = 0; n < 400 && held !== 1'b1; n++) @(posedge clk_sys_in);
    if (held !== 1'b1) hang();
  endtask : wait_held
  task automatic meas(input logic c, input logic st, input logic sp, input logic src, input logic [1:0] dv,
                      input logic [7:0] k);
    int per;
    per = src ? (c ? 1 : 4) : (c ? 2 : 1);
    lfsr_q = lfsr_next(lfsr_q);
    apb(1'b1, `CLST_ADDR_CTRL, {{3{lfsr_q}}, 2'b10, dv, src, sp, st, c}, '0);
    apb(1'b0, `CLST_ADDR_CTRL, '0, {29'h0, dv, src, sp, st, c});
    inject(c, {1'b0, st}, {1'b0, k});
    inject(~c, {1'b0, st}, {1'b1, k});
    apb(1'b0, `CLST_ADDR_RESULT, '0, '0);
    inject(c, {1'b0, st}, {1'b1, k});
    s = t_mark;
    lfsr_q = lfsr_next(lfsr_q);
    repeat (int'(lfsr_q[6:0]) + 20) @(posedge clk_sys_in);
    inject(c, {1'b0, st}, {1'b1, k});
    inject(c, {1'b1, sp}, {1'b1, k});
    s = t_mark - s;
    wait_held();
    inject(c, {1'b0, st}, {1'b1, k});
    inject(c, {1'b1, sp}, {1'b1, k});
    apb(1'b0, `CLST_ADDR_STATUS, '0, 35'h2);
    apb(1'b0, `CLST_ADDR_RESULT, '0, {3'h1, 32'((s / per) >> dv)});
    apb(1'b0, `CLST_ADDR_RESULT, '0, '0);
  endtask : meas
  initial begin
    repeat (20) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      meas(i[0], i[1], ~i[1], i[0] ^ i[1], 2'(i), commas[i % 3]);
      $display("test %0d done", i);
    end
    apb(1'b1, `CLST_ADDR_CTRL, 32'hc0, '0);
    strap <= 1'b1;
    s = cyc;
    repeat (10) @(posedge clk_sys_in);
    apb(1'b0, `CLST_ADDR_STATUS, '0, 35'h5);
    repeat (30) @(posedge clk_sys_in);
    strap <= 1'b0;
    s = cyc - s;
    wait_held();
    apb(1'b0, `CLST_ADDR_RESULT, '0, {3'h2, 32'(s)});
    apb(1'b1, `CLST_ADDR_CTRL, 32'h80, '0);
    apb(1'b1, 12'h00c, {4{lfsr_q}}, 35'h4_0000_0000);
    apb(1'b0, 12'h00c, '0, 35'h4_0000_0000);
    apb(1'b0, `CLST_ADDR_CTRL, '0, 35'h0);
    $display("test manual and unmapped done");
    complete_run();
  end
endmodule : tb_clst_stopwatch
`default_nettype wire
